// ---- intc_pkg.sv ----
// Constants and carrier types for the interrupt priority controller.
package intc_pkg;

  // ==========================================================
  // Sizes
  localparam int NUM_SRC       = 64;
  localparam int FLAG_REGS     = NUM_SRC / 16;
  localparam int PRIO_REGS     = NUM_SRC / 4;
  localparam int NUM_EXT       = 3;
  localparam int IDX_W         = 6;

  // ==========================================================
  // Byte offsets
  localparam logic [7:0] OFS_GIC1     = 8'h00;
  localparam logic [7:0] OFS_GIC2     = 8'h04;
  localparam logic [7:0] OFS_PEND     = 8'h08;
  localparam logic [7:0] OFS_SR       = 8'h0c;
  localparam logic [7:0] OFS_CORE_CONTROL_WORD   = 8'h10;
  localparam logic [7:0] OFS_EVT_STAT = 8'h14;
  localparam logic [7:0] OFS_EVT_MASK = 8'h18;
  localparam logic [7:0] OFS_FLAG     = 8'h40;
  localparam logic [7:0] OFS_ENA      = 8'h60;
  localparam logic [7:0] OFS_PRIO     = 8'h80;
  localparam logic [7:0] OFS_PRIO_END = 8'hc0;

  // ==========================================================
  // Field positions and values
  localparam int         NEST_DIS_BIT  = 15;
  localparam logic [15:0] TRAP_MASK    = 16'h7fde;
  localparam int         ALT_TBL_BIT   = 15;
  localparam int         IPL_LSB       = 5;
  localparam int         IPL_MSB_BIT   = 3;
  localparam logic [15:0] CORE_CONTROL_WORD_RST   = 16'h0020;
  localparam logic [6:0] VEC_BASE      = 7'h08;
  localparam int         PRIO_W        = 3;
  localparam int         PRIO_STRIDE   = 4;
  localparam int         EVT_W         = 2;
  localparam int         EVT_PEND      = 0;
  localparam int         EVT_TRAP      = 1;
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic [1:0] HTRANS_SEQ    = 2'b11;

  // Primary and alternate table entry of source 0
  localparam logic [23:0] IVT_BASE  = 24'h000014;
  localparam logic [23:0] ALTERNATE_VECTOR_TABLE_BASE = 24'h000114;
  localparam logic [23:0] VEC_STEP  = 24'h000002;

  // External request sources by natural order
  localparam logic [IDX_W-1:0] EXT_SRC [NUM_EXT] = '{6'h00, 6'h14, 6'h1d};

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic       valid;
    logic [6:0] vector;
    logic [3:0] level;
  } pending_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
  } bus_req_t;

endpackage

// ---- interrupt_priority_control.sv ----
// Interrupt controller registers, priority resolution and AHB-Lite slave.
//
// Functional notes
// - Twenty-seven interrupt registers: two global controls, flags, enables, priorities, pending.
// - Global control one holds nesting disable plus trap source flags.
// - Global control two sets external pin edge polarity and alternate table selection.
// - Each source owns one flag set by its request and cleared only by software.
// - Each source has its own enable bit.
// - Each user source has a three-bit priority selecting one of eight levels.
// - Pending register latches a 7-bit vector number and 4-bit level.
// - Flag, enable and priority bits follow vector order, vector 8 at bit 0 of register 0.
// - Status word bits 7:5 hold the low CPU level bits, writable by software.
// - The CPU level MSB lives in core control and software cannot set it.
// - The three level bits encode 0 to 7, with 7 masking all user sources.
// - The MSB forms levels 8 to 15 and while set masks all user sources.
// - With nesting disable set the level bits ignore software writes.
// - Source 0 uses vector 8 at table entries 0x000014 or 0x000114.
//
// Design decisions made here: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module interrupt_priority_control
  import intc_pkg::*;
(
  // Clock and reset
  input  wire logic                clock,
  input  wire logic                rst_n,
  // AHB-Lite slave
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic                hready,
  input  wire logic [31:0]         hwdata,
  output logic [31:0]              hrdata,
  output logic                     hreadyout,
  output logic                     hresp,
  // Request sources
  input  wire logic [NUM_SRC-1:0]  src_req,
  input  wire logic [NUM_EXT-1:0]  ext_pin,
  input  wire logic [15:0]         trap_evt,
  // CPU side
  output logic                     cpu_int_req,
  output logic [6:0]               cpu_int_vector,
  output logic [3:0]               cpu_int_level,
  output logic [23:0]              cpu_vec_addr,
  // Interrupt to system
  output logic                     irq
);

  // ==========================================================
  // Storage
  logic [15:0]            gic1_ff;
  logic [15:0]            gic2_ff;
  logic [2:0]             ipl_ff;
  logic [15:0]            core_control_word_ff;
  logic [NUM_SRC-1:0]     flag_ff;
  logic [NUM_SRC-1:0]     ena_ff;
  logic [PRIO_W-1:0]      prio_ff [NUM_SRC];
  pending_t               pend_ff;
  logic [EVT_W-1:0]       evt_stat_ff;
  logic [EVT_W-1:0]       evt_mask_ff;
  bus_req_t               req_ff;
  logic [31:0]            hrdata_ff;
  logic                   irq_ff;
  logic [23:0]            vec_addr_ff;
  logic [NUM_EXT-1:0]     ext_meta_ff;
  logic [NUM_EXT-1:0]     ext_sync_ff;
  logic [NUM_EXT-1:0]     ext_prev_ff;

  logic                   wr_en;
  logic [15:0]            wdat;
  logic [NUM_SRC-1:0]     ext_set;
  logic [NUM_SRC-1:0]     nxt_flag;
  logic [15:0]            trap_set;
  logic [3:0]             cur_level;
  pending_t               nxt_pend;
  logic [31:0]            rd_val;

  // Bank ends, one word per sixteen sources
  localparam logic [7:0]  FLAG_END = OFS_FLAG + 8'(FLAG_REGS * 4);
  localparam logic [7:0]  ENA_END  = OFS_ENA + 8'(FLAG_REGS * 4);

  function automatic logic in_bank(input logic [7:0] a, input logic [7:0] base,
                                   input logic [7:0] last);
    return (a >= base) && (a < last);
  endfunction

  function automatic int bank_idx(input logic [7:0] a, input logic [7:0] base);
    return int'((a - base) >> 2);
  endfunction

  // ==========================================================
  // AHB-Lite address and data phase
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      req_ff <= '0;
    end else if (hready) begin
      req_ff.wr   <= hsel && hwrite && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
      req_ff.rd   <= hsel && !hwrite && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
      req_ff.addr <= haddr[7:0];
    end else begin
      req_ff <= req_ff;
    end
  end

  assign wr_en = req_ff.wr;
  assign wdat  = hwdata[15:0];

  // Read data stands one data phase, zero otherwise
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      hrdata_ff <= '0;
    end else if (hready && hsel && !hwrite && htrans[1]) begin
      hrdata_ff <= rd_val;
    end else begin
      hrdata_ff <= '0;
    end
  end

  // Read decode in the address phase
  // unmapped words read zero
  always_comb begin
    rd_val = '0;
    if (in_bank(haddr[7:0], OFS_FLAG, FLAG_END)) begin
      rd_val[15:0] = flag_ff[bank_idx(haddr[7:0], OFS_FLAG)*16 +: 16];
    end else if (in_bank(haddr[7:0], OFS_ENA, ENA_END)) begin
      rd_val[15:0] = ena_ff[bank_idx(haddr[7:0], OFS_ENA)*16 +: 16];
    end else if (in_bank(haddr[7:0], OFS_PRIO, OFS_PRIO_END)) begin
      for (int k = 0; k < PRIO_STRIDE; k++) begin
        rd_val[k*PRIO_STRIDE +: PRIO_W] = prio_ff[bank_idx(haddr[7:0], OFS_PRIO)*4 + k];
      end
    end else begin
      unique case (haddr[7:0])
        OFS_GIC1:     rd_val[15:0] = gic1_ff;
        OFS_GIC2:     rd_val[15:0] = gic2_ff;
        OFS_PEND:     rd_val[15:0] = {4'h0, pend_ff.level, 1'b0, pend_ff.vector};
        OFS_SR:       rd_val[IPL_LSB +: 3] = ipl_ff;
        OFS_CORE_CONTROL_WORD:   rd_val[15:0] = core_control_word_ff;
        OFS_EVT_STAT: rd_val[EVT_W-1:0] = evt_stat_ff;
        OFS_EVT_MASK: rd_val[EVT_W-1:0] = evt_mask_ff;
        default:      rd_val = '0;
      endcase
    end
  end

  // Zero wait states, always OKAY
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      hresp <= 1'b0;
      hreadyout <= 1'b1;
    end else begin
      hresp <= 1'b0;
      hreadyout <= 1'b1;
    end
  end

  assign hrdata = hrdata_ff;

  // ==========================================================
  // Global control registers
  assign trap_set = trap_evt & TRAP_MASK;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      gic1_ff <= '0;
    end else if (wr_en && req_ff.addr == OFS_GIC1) begin
      gic1_ff <= (wdat & (TRAP_MASK | (16'h0001 << NEST_DIS_BIT))) | trap_set;
    end else begin
      gic1_ff <= gic1_ff | trap_set;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      gic2_ff <= '0;
    end else if (wr_en && req_ff.addr == OFS_GIC2) begin
      gic2_ff <= wdat & ((16'h0001 << ALT_TBL_BIT) | 16'((1 << NUM_EXT) - 1));
    end
  end

  // ==========================================================
  // External pins: sync, then edge per polarity bit
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ext_meta_ff <= '0;
      ext_sync_ff <= '0;
      ext_prev_ff <= '0;
    end else begin
      ext_meta_ff <= ext_pin;
      ext_sync_ff <= ext_meta_ff;
      ext_prev_ff <= ext_sync_ff;
    end
  end

  always_comb begin
    ext_set = '0;
    for (int e = 0; e < NUM_EXT; e++) begin
      ext_set[EXT_SRC[e]] = gic2_ff[e] ? (ext_prev_ff[e] & ~ext_sync_ff[e])
                                       : (~ext_prev_ff[e] & ext_sync_ff[e]);
    end
  end

  // ==========================================================
  // Flags, enables, priorities
  // set wins over software clear
  always_comb begin
    nxt_flag = flag_ff;
    if (wr_en && in_bank(req_ff.addr, OFS_FLAG, FLAG_END)) begin
      nxt_flag[bank_idx(req_ff.addr, OFS_FLAG)*16 +: 16] = wdat;
    end
    nxt_flag = nxt_flag | src_req | ext_set;
  end

  // bit n%16 of bank n/16 is source n
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      flag_ff <= '0;
    end else begin
      flag_ff <= nxt_flag;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ena_ff <= '0;
    end else if (wr_en && in_bank(req_ff.addr, OFS_ENA, ENA_END)) begin
      ena_ff[bank_idx(req_ff.addr, OFS_ENA)*16 +: 16] <= wdat;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      for (int s = 0; s < NUM_SRC; s++) begin
        prio_ff[s] <= '0;
      end
    end else if (wr_en && in_bank(req_ff.addr, OFS_PRIO, OFS_PRIO_END)) begin
      for (int k = 0; k < PRIO_STRIDE; k++) begin
        prio_ff[bank_idx(req_ff.addr, OFS_PRIO)*4 + k] <= wdat[k*PRIO_STRIDE +: PRIO_W];
      end
    end
  end

  // ==========================================================
  // CPU priority level
  // level bits, locked by nesting disable
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ipl_ff <= '0;
    end else if (wr_en && req_ff.addr == OFS_SR && !gic1_ff[NEST_DIS_BIT]) begin
      ipl_ff <= wdat[IPL_LSB +: 3];
    end
  end

  // MSB cleared by software, set only by a trap
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      core_control_word_ff <= CORE_CONTROL_WORD_RST;
    end else begin
      if (wr_en && req_ff.addr == OFS_CORE_CONTROL_WORD) begin
        core_control_word_ff <= {wdat[15:IPL_MSB_BIT+1],
                      core_control_word_ff[IPL_MSB_BIT] & wdat[IPL_MSB_BIT],
                      wdat[IPL_MSB_BIT-1:0]};
      end
      if (|trap_set) begin
        core_control_word_ff[IPL_MSB_BIT] <= 1'b1;
      end
    end
  end

  assign cur_level = {core_control_word_ff[IPL_MSB_BIT], ipl_ff};

  // ==========================================================
  // Priority resolution
  // flagged, enabled, above level; ties go to natural order
  always_comb begin
    nxt_pend = '0;
    for (int s = NUM_SRC - 1; s >= 0; s--) begin
      if (flag_ff[s] && ena_ff[s] && ({1'b0, prio_ff[s]} > cur_level)
          && (!nxt_pend.valid || {1'b0, prio_ff[s]} >= nxt_pend.level)) begin
        nxt_pend.valid  = 1'b1;
        // vector is natural order plus eight
        nxt_pend.vector = VEC_BASE + 7'(s);
        nxt_pend.level  = {1'b0, prio_ff[s]};
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pend_ff <= '0;
    end else begin
      pend_ff <= nxt_pend;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      vec_addr_ff <= '0;
    end else begin
      vec_addr_ff <= (gic2_ff[ALT_TBL_BIT] ? ALTERNATE_VECTOR_TABLE_BASE : IVT_BASE)
                     + VEC_STEP * 24'(nxt_pend.vector - VEC_BASE);
    end
  end

  assign cpu_int_req    = pend_ff.valid;
  assign cpu_int_vector = pend_ff.vector;
  assign cpu_int_level  = pend_ff.level;
  assign cpu_vec_addr   = vec_addr_ff;

  // ==========================================================
  // Event status, mask and interrupt line
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      evt_stat_ff <= '0;
      evt_mask_ff <= '0;
      irq_ff      <= 1'b0;
    end else begin
      evt_stat_ff <= (evt_stat_ff
                      & ~((wr_en && req_ff.addr == OFS_EVT_STAT) ? wdat[EVT_W-1:0] : '0))
                     | {(|trap_set), (nxt_pend.valid && !pend_ff.valid)};
      if (wr_en && req_ff.addr == OFS_EVT_MASK) begin
        evt_mask_ff <= wdat[EVT_W-1:0];
      end
      irq_ff <= |(evt_stat_ff & evt_mask_ff);
    end
  end

  assign irq = irq_ff;

endmodule

`default_nettype wire

// ---- periph_model.sv ----
// Peripheral and pin request sources facing the interrupt controller.
`timescale 1ns/1ps
`default_nettype none

module periph_model (
  // Clock
  input  wire logic        clock,
  // Commands from the bench
  input  wire logic        fire,
  input  wire logic [5:0]  sel,
  input  wire logic        ext_cmd,
  // Request lines
  output var logic [63:0]  src_req,
  output var logic [2:0]   ext_pin
);
  always_ff @(posedge clock) begin
    src_req <= fire ? (64'h1 << sel) : 64'h0;
  end
  always_ff @(posedge clock) begin
    ext_pin <= {2'b00, ext_cmd};
  end
endmodule
`default_nettype wire

// ---- interrupt_priority_control_sva.sv ----
// Port-level checks of the interrupt priority controller.
`timescale 1ns/1ps
`default_nettype none

module intc_chk
  import intc_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // Bus
  input  wire logic        hsel,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  input  wire logic        hreadyout,
  input  wire logic        hresp,
  // Sources and CPU side
  input  wire logic [15:0] trap_evt,
  input  wire logic        cpu_int_req,
  input  wire logic [6:0]  cpu_int_vector,
  input  wire logic [3:0]  cpu_int_level,
  input  wire logic [23:0] cpu_vec_addr,
  input  wire logic        irq
);
  logic [23:0] ofs;
  assign ofs = {16'h0, cpu_int_vector - VEC_BASE, 1'b0};
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // Steps
  sequence trap_hit;
    |(trap_evt & TRAP_MASK);
  endsequence
  sequence user_masked;
    ##3 !cpu_int_req [*3];
  endsequence
  // ==========================================================
  // Checks
  bus_okay_a: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  bus_ready_a: assert property (hreadyout == 1'b1)
    else $error("bus slave stalled");
  rdata_idle_a: assert property (
    !(hsel && hready && htrans[1] && !hwrite) |=> hrdata == 32'h0)
    else $error("read data outside data phase");
  reset_quiet_a: assert property ($rose(rst_n) |-> !cpu_int_req && !irq)
    else $error("request active after reset");
  level_user_a: assert property (
    cpu_int_req |-> cpu_int_level inside {[4'd1:4'd7]})
    else $error("pending level out of user range");
  vec_range_a: assert property (
    cpu_int_req |-> cpu_int_vector >= VEC_BASE && cpu_int_vector < 7'd72)
    else $error("vector outside source range");
  vec_addr_a: assert property (
    cpu_int_req |-> cpu_vec_addr == IVT_BASE + ofs || cpu_vec_addr == ALTERNATE_VECTOR_TABLE_BASE + ofs)
    else $error("table entry does not match vector");
  trap_mask_a: assert property (trap_hit |-> user_masked)
    else $error("user request not masked after trap");
endmodule

bind interrupt_priority_control intc_chk intc_chk_i (
  .clock(clock), .rst_n(rst_n), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .trap_evt(trap_evt), .cpu_int_req(cpu_int_req), .cpu_int_vector(cpu_int_vector),
  .cpu_int_level(cpu_int_level), .cpu_vec_addr(cpu_vec_addr), .irq(irq));
`default_nettype wire

// ---- interrupt_priority_control_test.sv ----
// Self-checking bench of the interrupt priority controller.
`timescale 1ns/1ps
`default_nettype none

module interrupt_priority_control_test import intc_pkg::*;;
  logic        clock = 0, rst_n = 0, hsel = 0, hwrite = 0, fire = 0, ext_cmd = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
  logic [1:0]  htrans = 0;
  logic [15:0] trap_evt = 0;
  logic [5:0]  sel = 0;
  logic [63:0] src_req;
  logic [2:0]  ext_pin;
  logic        hreadyout, hresp, cpu_int_req, irq;
  logic [6:0]  cpu_int_vector;
  logic [3:0]  cpu_int_level;
  logic [23:0] cpu_vec_addr;
  int          num_errors = 0, tests_run = 0, s, p, l;

  always #4 clock = ~clock;

  interrupt_priority_control interrupt_priority_control_i (.clock(clock), .rst_n(rst_n),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .src_req(src_req), .ext_pin(ext_pin), .trap_evt(trap_evt),
    .cpu_int_req(cpu_int_req), .cpu_int_vector(cpu_int_vector),
    .cpu_int_level(cpu_int_level), .cpu_vec_addr(cpu_vec_addr), .irq(irq));
  periph_model periph_model_i (.clock(clock), .fire(fire), .sel(sel),
    .ext_cmd(ext_cmd), .src_req(src_req), .ext_pin(ext_pin));

  // ==========================================================
  // Helpers
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic tick(inout int n);
    @(posedge clock);
    n++;
    if (n > 99) begin
      num_errors++;
      test_done();
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= w;
    tick(n);
    while (hreadyout !== 1'b1) tick(n);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    tick(n);
    while (hreadyout !== 1'b1) tick(n);
    q = hrdata;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic fin(input string nm);
    $display("test %s done", nm);
  endtask
  function automatic logic [7:0] bank(input logic [7:0] b, input int s);
    return b + 8'(4 * (s / 16));
  endfunction
  function automatic logic [23:0] vaddr(input int s, input logic alt);
    return (alt ? ALTERNATE_VECTOR_TABLE_BASE : IVT_BASE) + 24'(s) * VEC_STEP;
  endfunction
  task automatic arm(input int s, input int p);
    bus(1'b1, bank(OFS_ENA, s), 32'h1 << (s % 16));
    bus(1'b1, OFS_PRIO + 8'(4 * (s / 4)), 32'(p) << (4 * (s % 4)));
    fire <= 1'b1;
    sel <= 6'(s);
    @(posedge clock);
    fire <= 1'b0;
  endtask

  // ==========================================================
  // Scenarios
  initial begin
    s = $urandom(32'h22d5);
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    bus(1'b0, OFS_SR, 0);
    chk("status word", 0, q);
    bus(1'b0, OFS_CORE_CONTROL_WORD, 0);
    chk("core control", CORE_CONTROL_WORD_RST, q);
    bus(1'b1, OFS_CORE_CONTROL_WORD, 32'h28);
    bus(1'b0, OFS_CORE_CONTROL_WORD, 0);
    chk("level msb", 0, q & 32'h8);
    bus(1'b1, 8'h30, '1);
    bus(1'b0, 8'h30, 0);
    chk("unmapped", 0, q);
    chk("response", 0, hresp);
    fin("registers");
    for (int i = 0; i < 6; i++) begin
      s = $urandom_range(63, 1);
      p = (i == 0) ? 1 : (i == 1) ? 7 : $urandom_range(7, 1);
      l = (i == 0) ? 0 : (i == 1) ? 7 : $urandom_range(7, 0);
      bus(1'b1, OFS_SR, 32'(l) << IPL_LSB);
      bus(1'b0, OFS_SR, 0);
      chk("level", 32'(l) << IPL_LSB, q);
      arm(s, p);
      repeat (4) @(posedge clock);
      chk("request", 32'(p > l), cpu_int_req);
      if (p > l) begin
        chk("vector", 32'(s) + 8, cpu_int_vector);
        chk("address", vaddr(s, 1'b0), cpu_vec_addr);
        bus(1'b0, OFS_PEND, 0);
        chk("pending", {20'h0, 4'(p), 1'b0, 7'(s) + VEC_BASE}, q & 32'hf7f);
      end
      bus(1'b0, bank(OFS_FLAG, s), 0);
      chk("flag", 32'h1 << (s % 16), q);
      bus(1'b1, bank(OFS_FLAG, s), 0);
      bus(1'b1, bank(OFS_ENA, s), 0);
      bus(1'b0, bank(OFS_FLAG, s), 0);
      chk("flag clear", 0, q);
    end
    fin("levels");
    bus(1'b1, OFS_SR, 0);
    bus(1'b1, OFS_GIC1, 32'h8000);
    bus(1'b1, OFS_SR, 32'he0);
    bus(1'b0, OFS_SR, 0);
    chk("level locked", 0, q & 32'he0);
    bus(1'b1, OFS_GIC1, 0);
    bus(1'b1, OFS_SR, 0);
    fin("lock");
    arm(5, 7);
    bus(1'b1, OFS_EVT_STAT, 3);
    bus(1'b1, OFS_EVT_MASK, 2);
    trap_evt <= 16'h0002;
    @(posedge clock);
    trap_evt <= 16'h0;
    repeat (4) @(posedge clock);
    chk("trap mask", 0, cpu_int_req);
    chk("irq set", 1, irq);
    bus(1'b0, OFS_CORE_CONTROL_WORD, 0);
    chk("msb set", 8, q & 32'h8);
    bus(1'b0, OFS_GIC1, 0);
    chk("trap flag", 2, q & TRAP_MASK);
    bus(1'b1, OFS_EVT_MASK, 0);
    repeat (2) @(posedge clock);
    chk("irq masked", 0, irq);
    bus(1'b1, OFS_EVT_MASK, 2);
    repeat (2) @(posedge clock);
    chk("irq unmasked", 1, irq);
    bus(1'b1, OFS_EVT_STAT, 2);
    repeat (2) @(posedge clock);
    chk("irq cleared", 0, irq);
    bus(1'b1, OFS_CORE_CONTROL_WORD, 0);
    bus(1'b1, OFS_GIC1, 0);
    repeat (4) @(posedge clock);
    chk("trap released", 1, cpu_int_req);
    fin("trap");
    bus(1'b1, OFS_GIC2, 32'h8000);
    repeat (4) @(posedge clock);
    chk("alternate", vaddr(5, 1'b1), cpu_vec_addr);
    bus(1'b1, OFS_GIC2, 0);
    fin("alternate");
    bus(1'b1, OFS_FLAG, 0);
    bus(1'b1, OFS_ENA, 1);
    bus(1'b1, OFS_PRIO, 3);
    ext_cmd <= 1'b1;
    repeat (8) @(posedge clock);
    chk("ext request", 1, cpu_int_req);
    chk("ext vector", VEC_BASE, cpu_int_vector);
    chk("ext address", IVT_BASE, cpu_vec_addr);
    fin("external");
    test_done();
  end
endmodule
`default_nettype wire
